// ### servo_host_model.sv
`timescale 1ns/10ps
module servo_host_model (
  // Clock.
  input  wire logic        clk_sys_in,
  // Requests from the bench.
  input  wire logic        son_req_in,
  input  wire logic        cw_over_in,
  input  wire logic        ccw_over_in,
  input  wire logic [15:0] speed_req_in,
  // Lines into the drive.
  output logic             servo_enable_out,
  output logic             cw_limit_out,
  output logic             ccw_limit_out,
  output logic      [15:0] motor_speed_out
);
  initial begin
    servo_enable_out = 1'b0;
    cw_limit_out = 1'b1;
    ccw_limit_out = 1'b1;
    motor_speed_out = 16'h0000;
  end
  // Normally closed switches read high in the safe range and open on over-travel.
  always @(posedge clk_sys_in) begin
    cw_limit_out <= !cw_over_in;
    ccw_limit_out <= !ccw_over_in;
    servo_enable_out <= son_req_in;
    motor_speed_out <= speed_req_in;
  end
endmodule

// ### servo_seq.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
module servo_seq #(
  parameter int unsigned MS_TICK = servo_seq_pkg::MS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Drive side.
  input  wire logic        servo_enable_in,
  input  wire logic        cw_limit_in,
  input  wire logic        ccw_limit_in,
  input  wire logic        alarm_in,
  input  wire logic [15:0] motor_speed_in,
  input  wire logic [15:0] torque_cmd_in,
  output logic             ready_out,
  output logic             power_stage_on_out,
  output logic             brake_release_out,
  output logic      [15:0] torque_out,
  // Interrupt.
  output logic             irq_out
);
  import servo_seq_pkg::*;

  logic [1:0]        overtravel_select_r;
  logic              filt_en_r;
  tq_src_t           tq_src_r;
  logic [15:0]       standstill_speed_threshold_r;
  logic [15:0]       standstill_brake_delay_r;
  logic [15:0]       running_brake_wait_r;
  logic [15:0]       running_brake_speed_r;
  logic [15:0]       int_ccw_torque_limit_r;
  logic [15:0]       int_cw_torque_limit_r;
  logic [15:0]       ext_ccw_torque_limit_r;
  logic [15:0]       ext_cw_torque_limit_r;
  logic [15:0]       testrun_torque_limit_r;
  logic [15:0]       torque_filter_tc_r;
  logic [IRQ_W-1:0]  irq_status_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_event;
  logic [31:0]       rd_data;
  logic              rd_hit;
  logic              apb_done;
  logic              wr_en;
  logic              status_read;
  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic [17:0]       tick_cnt_r;
  logic              ms_tick;
  logic [15:0]       ms_cnt_r;
  logic [11:0]       filt_cnt_r;
  logic              filt_step;
  logic [16:0]       filt_gain;
  logic signed [31:0] filt_acc_r;
  logic signed [15:0] filt_y;
  logic signed [15:0] lim_hi;
  logic signed [15:0] lim_lo;
  logic signed [15:0] tq_limited;
  logic signed [15:0] tq_filtered;
  logic signed [15:0] tq_final;
  logic signed [16:0] filt_err;
  logic signed [33:0] filt_prod;
  logic              ot_cw;
  logic              ot_ccw;
  logic              ot_cw_d_r;
  logic              ot_ccw_d_r;
  logic              alarm_d_r;
  logic              ready_nxt;
  logic              power_nxt;
  logic              brake_rel_nxt;

  // Delay, torque limit and filter time constant writes are clamped into their legal ranges.
  function automatic logic [15:0] clamp_pos(input logic [15:0] v);
    if (v[15]) begin
      return 16'h0000;
    end else if (v > TQ_LIM_MAX) begin
      return TQ_LIM_MAX;
    end
    return v;
  endfunction

  function automatic logic [15:0] clamp_neg(input logic [15:0] v);
    if (!v[15]) begin
      return 16'h0000;
    end else if ($signed(v) < -$signed(TQ_LIM_MAX)) begin
      return 16'(-$signed(TQ_LIM_MAX));
    end
    return v;
  endfunction

  function automatic logic [15:0] clamp_delay(input logic [15:0] v);
    return (v > DELAY_MAX) ? DELAY_MAX : v;
  endfunction

  // The slave answers in the cycle after setup, so every access has no wait state.
  assign apb_done    = psel_in && penable_in && pready_out;
  assign wr_en       = apb_done && pwrite_in && rd_hit;
  assign status_read = apb_done && !pwrite_in && (paddr_in == ADDR_IRQ_STATUS);

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr_in)
      ADDR_CTRL: begin
        rd_data[CTRL_OT_LSB +: 2]  = overtravel_select_r;
        rd_data[CTRL_FILT_EN]      = filt_en_r;
        rd_data[CTRL_SRC_LSB +: 2] = tq_src_r;
      end
      ADDR_STILL_SPEED: rd_data[15:0] = standstill_speed_threshold_r;
      ADDR_STILL_DELAY: rd_data[15:0] = standstill_brake_delay_r;
      ADDR_RUN_WAIT:    rd_data[15:0] = running_brake_wait_r;
      ADDR_RUN_SPEED:   rd_data[15:0] = running_brake_speed_r;
      ADDR_INT_CCW:     rd_data[15:0] = int_ccw_torque_limit_r;
      ADDR_INT_CW:      rd_data[15:0] = int_cw_torque_limit_r;
      ADDR_EXT_CCW:     rd_data[15:0] = ext_ccw_torque_limit_r;
      ADDR_EXT_CW:      rd_data[15:0] = ext_cw_torque_limit_r;
      ADDR_TEST_LIM:    rd_data[15:0] = testrun_torque_limit_r;
      ADDR_FILT_TC:     rd_data[15:0] = torque_filter_tc_r;
      ADDR_STATUS: begin
        rd_data[STAT_READY]          = ready_out;
        rd_data[STAT_POWER]          = power_stage_on_out;
        rd_data[STAT_BRAKE_REL]      = brake_release_out;
        rd_data[STAT_OT_CW]          = ot_cw;
        rd_data[STAT_OT_CCW]         = ot_ccw;
        rd_data[STAT_STATE_LSB +: 3] = state_r;
      end
      ADDR_IRQ_STATUS:  rd_data[IRQ_W-1:0] = irq_status_r;
      ADDR_IRQ_MASK:    rd_data[IRQ_W-1:0] = irq_mask_r;
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_data : 32'h0000_0000;
      pslverr_out <= psel_in && !penable_in && !rd_hit;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      overtravel_select_r          <= RST_OT_SEL;
      filt_en_r                    <= RST_FILT_EN;
      tq_src_r                     <= TQ_INTERNAL;
      standstill_speed_threshold_r <= RST_STILL_SPEED;
      standstill_brake_delay_r     <= RST_STILL_DELAY;
      running_brake_wait_r         <= RST_RUN_WAIT;
      running_brake_speed_r        <= RST_RUN_SPEED;
      int_ccw_torque_limit_r       <= RST_CCW_LIM;
      int_cw_torque_limit_r        <= RST_CW_LIM;
      ext_ccw_torque_limit_r       <= RST_CCW_LIM;
      ext_cw_torque_limit_r        <= RST_CW_LIM;
      testrun_torque_limit_r       <= RST_CCW_LIM;
      torque_filter_tc_r           <= RST_FILT_TC;
      irq_mask_r                   <= RST_IRQ_MASK;
    end else if (wr_en) begin
      unique case (paddr_in)
        ADDR_CTRL: begin
          overtravel_select_r <= pwdata_in[CTRL_OT_LSB +: 2];
          filt_en_r           <= pwdata_in[CTRL_FILT_EN];
          // An unused source code falls back to the internal limits.
          tq_src_r <= (pwdata_in[CTRL_SRC_LSB +: 2] == 2'h3) ? TQ_INTERNAL : tq_src_t'(pwdata_in[CTRL_SRC_LSB +: 2]);
        end
        ADDR_STILL_SPEED: standstill_speed_threshold_r <= pwdata_in[15:0];
        ADDR_STILL_DELAY: standstill_brake_delay_r     <= clamp_delay(pwdata_in[15:0]);
        ADDR_RUN_WAIT:    running_brake_wait_r         <= clamp_delay(pwdata_in[15:0]);
        ADDR_RUN_SPEED:   running_brake_speed_r        <= pwdata_in[15:0];
        ADDR_INT_CCW:     int_ccw_torque_limit_r       <= clamp_pos(pwdata_in[15:0]);
        ADDR_INT_CW:      int_cw_torque_limit_r        <= clamp_neg(pwdata_in[15:0]);
        ADDR_EXT_CCW:     ext_ccw_torque_limit_r       <= clamp_pos(pwdata_in[15:0]);
        ADDR_EXT_CW:      ext_cw_torque_limit_r        <= clamp_neg(pwdata_in[15:0]);
        ADDR_TEST_LIM:    testrun_torque_limit_r       <= clamp_pos(pwdata_in[15:0]);
        ADDR_FILT_TC: begin
          if (pwdata_in[15:0] < FILT_TC_MIN) begin
            torque_filter_tc_r <= FILT_TC_MIN;
          end else if (pwdata_in[15:0] > FILT_TC_MAX) begin
            torque_filter_tc_r <= FILT_TC_MAX;
          end else begin
            torque_filter_tc_r <= pwdata_in[15:0];
          end
        end
        ADDR_IRQ_MASK:    irq_mask_r <= pwdata_in[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Limit inputs are high while the switch is closed inside the safe range.
  always_comb begin
    ot_cw  = 1'b0;
    ot_ccw = 1'b0;
    unique case (overtravel_select_r)
      2'h0: begin
        ot_cw  = !cw_limit_in;
        ot_ccw = !ccw_limit_in;
      end
      2'h1: ot_cw  = !cw_limit_in;
      2'h2: ot_ccw = !ccw_limit_in;
      2'h3: begin
      end
    endcase
  end

  // Millisecond tick restarts on each state change so delays are exact from entry.
  assign ms_tick = (tick_cnt_r == 18'(MS_TICK - 1));

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_r <= 18'h00000;
      ms_cnt_r   <= 16'h0000;
    end else if (state_nxt != state_r) begin
      tick_cnt_r <= 18'h00000;
      ms_cnt_r   <= 16'h0000;
    end else if (ms_tick) begin
      tick_cnt_r <= 18'h00000;
      ms_cnt_r   <= (ms_cnt_r == 16'hFFFF) ? ms_cnt_r : ms_cnt_r + 16'h0001;
    end else begin
      tick_cnt_r <= tick_cnt_r + 18'h00001;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POWERUP: begin
        if (ms_cnt_r >= 16'(READY_DELAY_MS) && !alarm_in) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (alarm_in) begin
          state_nxt = ST_ALARM;
        end else if (servo_enable_in) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (alarm_in) begin
          state_nxt = ST_ALARM;
        end else if (!servo_enable_in) begin
          if (motor_speed_in < standstill_speed_threshold_r) begin
            state_nxt = ST_STILL_BRK;
          end else begin
            state_nxt = ST_RUN_BRK;
          end
        end
      end
      ST_STILL_BRK: begin
        if (alarm_in) begin
          state_nxt = ST_ALARM;
        end else if (ms_cnt_r >= standstill_brake_delay_r) begin
          state_nxt = ST_READY;
        end
      end
      ST_RUN_BRK: begin
        if (alarm_in) begin
          state_nxt = ST_ALARM;
        end else if (ms_cnt_r >= running_brake_wait_r || motor_speed_in <= running_brake_speed_r) begin
          state_nxt = ST_READY;
        end
      end
      ST_ALARM: begin
        if (!alarm_in) begin
          state_nxt = ST_READY;
        end
      end
      default: state_nxt = ST_ALARM;
    endcase
  end

  always_comb begin
    ready_nxt     = (state_nxt != ST_POWERUP) && (state_nxt != ST_ALARM);
    power_nxt     = (state_nxt == ST_RUN) || (state_nxt == ST_STILL_BRK);
    brake_rel_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_RUN_BRK);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r            <= ST_POWERUP;
      ready_out          <= 1'b0;
      power_stage_on_out <= 1'b0;
      brake_release_out  <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      ready_out          <= ready_nxt;
      power_stage_on_out <= power_nxt;
      brake_release_out  <= brake_rel_nxt;
    end
  end

  // Torque limiting ahead of the filter.
  always_comb begin
    unique case (tq_src_r)
      TQ_EXTERNAL: begin
        lim_hi = $signed(ext_ccw_torque_limit_r);
        lim_lo = $signed(ext_cw_torque_limit_r);
      end
      TQ_TESTRUN: begin
        lim_hi = $signed(testrun_torque_limit_r);
        lim_lo = -$signed(testrun_torque_limit_r);
      end
      default: begin
        lim_hi = $signed(int_ccw_torque_limit_r);
        lim_lo = $signed(int_cw_torque_limit_r);
      end
    endcase
    if ($signed(torque_cmd_in) > lim_hi) begin
      tq_limited = lim_hi;
    end else if ($signed(torque_cmd_in) < lim_lo) begin
      tq_limited = lim_lo;
    end else begin
      tq_limited = $signed(torque_cmd_in);
    end
  end

  // First-order filter in 16.16 fixed point, stepped every 10 us; gain is step over time constant.
  assign filt_step = (filt_cnt_r == 12'(FILT_STEP_CYCLES - 1));
  assign filt_gain = 17'(FILT_ONE / {1'b0, torque_filter_tc_r});
  assign filt_y    = filt_acc_r[31:16];
  assign filt_err  = 17'(tq_limited) - 17'(filt_y);
  assign filt_prod = filt_err * $signed({1'b0, filt_gain});

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      filt_cnt_r <= 12'h000;
      filt_acc_r <= 32'sh0000_0000;
    end else begin
      filt_cnt_r <= filt_step ? 12'h000 : filt_cnt_r + 12'h001;
      if (!power_stage_on_out) begin
        filt_acc_r <= 32'sh0000_0000;
      end else if (filt_step) begin
        filt_acc_r <= filt_acc_r + 32'(filt_prod);
      end
    end
  end

  always_comb begin
    tq_filtered = filt_en_r ? filt_y : tq_limited;
    tq_final    = tq_filtered;
    // Only the blocked direction is cut, so a reverse command still backs out.
    if (ot_ccw && tq_filtered > 16'sh0000) begin
      tq_final = 16'sh0000;
    end
    if (ot_cw && tq_filtered < 16'sh0000) begin
      tq_final = 16'sh0000;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      torque_out <= 16'h0000;
    end else begin
      torque_out <= power_nxt ? 16'(tq_final) : 16'h0000;
    end
  end

  // Event capture; a read of the interrupt status register clears it, a new event wins.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ot_cw_d_r  <= 1'b0;
      ot_ccw_d_r <= 1'b0;
      alarm_d_r  <= 1'b0;
    end else begin
      ot_cw_d_r  <= ot_cw;
      ot_ccw_d_r <= ot_ccw;
      alarm_d_r  <= alarm_in;
    end
  end

  always_comb begin
    irq_event            = '0;
    irq_event[IRQ_READY] = ready_nxt && !ready_out;
    irq_event[IRQ_SON]   = (state_r != ST_RUN) && (state_nxt == ST_RUN);
    irq_event[IRQ_SOFF]  = (state_r == ST_RUN) && (state_nxt != ST_RUN);
    irq_event[IRQ_OT]    = (ot_cw && !ot_cw_d_r) || (ot_ccw && !ot_ccw_d_r);
    irq_event[IRQ_ALARM] = alarm_in && !alarm_d_r;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status_r <= '0;
      irq_out      <= 1'b0;
    end else begin
      irq_status_r <= (status_read ? '0 : irq_status_r) | irq_event;
      irq_out      <= |(((status_read ? '0 : irq_status_r) | irq_event) & irq_mask_r);
    end
  end

endmodule

// ### servo_seq_assertions.sv
`timescale 1ns/10ps
module servo_seq_assertions #(
  parameter int unsigned MS_TICK = 20
) (
  // Clock and reset.
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Register bus.
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Drive side.
  input wire logic        servo_enable_in,
  input wire logic        alarm_in,
  input wire logic        ready_out,
  input wire logic        power_stage_on_out,
  input wire logic        brake_release_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_pready;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_pready: assert property (p_pready) else $error("No answer after setup");
  property p_rdata_idle;
    !pready_out |-> prdata_out == 32'h00000000 && !pslverr_out;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside access");
  property p_alarm_off;
    $rose(alarm_in) |-> ##[1:2] !power_stage_on_out && !ready_out;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("Alarm left power on");
  property p_ready_first;
    $rose(power_stage_on_out) |-> $past(ready_out);
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("Power before ready");
  property p_son_on;
    ready_out && servo_enable_in && !alarm_in && !power_stage_on_out && !brake_release_out
      |-> ##[1:2] power_stage_on_out;
  endproperty
  a_son_on: assert property (p_son_on) else $error("Enable did not start power");
  property p_rise_both;
    $rose(power_stage_on_out) |-> brake_release_out;
  endproperty
  a_rise_both: assert property (p_rise_both) else $error("Brake held while powered");
  property p_run_brk;
    brake_release_out && !power_stage_on_out |=> !power_stage_on_out;
  endproperty
  a_run_brk: assert property (p_run_brk) else $error("Power back in brake wait");
  property p_still_brk;
    power_stage_on_out && !brake_release_out |=> !brake_release_out;
  endproperty
  a_still_brk: assert property (p_still_brk) else $error("Brake released in hold");

  c_run: cover property ($rose(power_stage_on_out));
  c_err: cover property (pslverr_out);
  c_irq: cover property ($rose(irq_out));
endmodule

bind servo_seq servo_seq_assertions #(.MS_TICK(MS_TICK)) chk_u (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .servo_enable_in(servo_enable_in), .alarm_in(alarm_in), .ready_out(ready_out),
  .power_stage_on_out(power_stage_on_out), .brake_release_out(brake_release_out), .irq_out(irq_out));

// ### servo_seq_pkg.sv
package servo_seq_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned MS_NS            = 1_000_000;
  localparam int unsigned MS_TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam real         READY_DELAY_S    = 1.5;
  localparam int unsigned READY_DELAY_MS   = int'(READY_DELAY_S * 1000.0);
  localparam int unsigned FILT_STEP_NS     = 10_000;
  localparam int unsigned FILT_STEP_CYCLES = FILT_STEP_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STILL_SPEED = 8'h04;
  localparam logic [7:0] ADDR_STILL_DELAY = 8'h08;
  localparam logic [7:0] ADDR_RUN_WAIT    = 8'h0C;
  localparam logic [7:0] ADDR_RUN_SPEED   = 8'h10;
  localparam logic [7:0] ADDR_INT_CCW     = 8'h14;
  localparam logic [7:0] ADDR_INT_CW      = 8'h18;
  localparam logic [7:0] ADDR_EXT_CCW     = 8'h1C;
  localparam logic [7:0] ADDR_EXT_CW      = 8'h20;
  localparam logic [7:0] ADDR_TEST_LIM    = 8'h24;
  localparam logic [7:0] ADDR_FILT_TC     = 8'h28;
  localparam logic [7:0] ADDR_STATUS      = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h34;

  // Control register fields.
  localparam int unsigned CTRL_OT_LSB  = 0;
  localparam int unsigned CTRL_FILT_EN = 2;
  localparam int unsigned CTRL_SRC_LSB = 3;

  // Status register fields.
  localparam int unsigned STAT_READY     = 0;
  localparam int unsigned STAT_POWER     = 1;
  localparam int unsigned STAT_BRAKE_REL = 2;
  localparam int unsigned STAT_OT_CW     = 3;
  localparam int unsigned STAT_OT_CCW    = 4;
  localparam int unsigned STAT_STATE_LSB = 8;

  // Interrupt bits.
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_SON   = 1;
  localparam int unsigned IRQ_SOFF  = 2;
  localparam int unsigned IRQ_OT    = 3;
  localparam int unsigned IRQ_ALARM = 4;
  localparam int unsigned IRQ_W     = 5;

  // Reset values and ranges.
  localparam logic [1:0]  RST_OT_SEL      = 2'h3;
  localparam logic        RST_FILT_EN     = 1'h1;
  localparam logic [15:0] RST_STILL_SPEED = 16'h0005;
  localparam logic [15:0] RST_STILL_DELAY = 16'h0000;
  localparam logic [15:0] RST_RUN_WAIT    = 16'h01F4;
  localparam logic [15:0] RST_RUN_SPEED   = 16'h0190;
  localparam logic [15:0] RST_CCW_LIM     = 16'h012C;
  localparam logic [15:0] RST_CW_LIM      = 16'hFED4;
  localparam logic [15:0] RST_FILT_TC     = 16'h00FA;
  localparam logic [15:0] DELAY_MAX       = 16'h07D0;
  localparam logic [15:0] TQ_LIM_MAX      = 16'h012C;
  localparam logic [15:0] FILT_TC_MIN     = 16'h000A;
  localparam logic [15:0] FILT_TC_MAX     = 16'h1388;
  localparam logic [16:0] FILT_ONE        = 17'h10000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 5'h00;

  typedef enum logic [1:0] {
    TQ_INTERNAL = 2'b00,
    TQ_EXTERNAL = 2'b01,
    TQ_TESTRUN  = 2'b10
  } tq_src_t;

  typedef enum logic [2:0] {
    ST_POWERUP    = 3'b000,
    ST_READY      = 3'b001,
    ST_RUN        = 3'b010,
    ST_STILL_BRK  = 3'b011,
    ST_RUN_BRK    = 3'b100,
    ST_ALARM      = 3'b101
  } seq_state_t;

endpackage

// ### servo_seq_tb.sv
`timescale 1ns/10ps
module servo_seq_tb;
  import servo_seq_pkg::*;
  localparam int unsigned TICK = 20;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
  logic pready_out, pslverr_out, se, ready_out, power_stage_on_out, brake_release_out, irq_out;
  logic servo_enable_in, cw_limit_in, ccw_limit_in, alarm_in = 1'b0;
  logic son_req = 1'b0, cw_over = 1'b0, ccw_over = 1'b0;
  logic [15:0] speed_req = 16'h0000, tq = 16'h0000, motor_speed_in, torque_out;
  int fails = 0, checked = 0, ticks = 0;

  servo_seq #(.MS_TICK(TICK)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .servo_enable_in(servo_enable_in), .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in),
    .alarm_in(alarm_in), .motor_speed_in(motor_speed_in), .torque_cmd_in(tq), .ready_out(ready_out),
    .power_stage_on_out(power_stage_on_out), .brake_release_out(brake_release_out),
    .torque_out(torque_out), .irq_out(irq_out));
  servo_host_model host_u (.clk_sys_in(clk_sys_in), .son_req_in(son_req), .cw_over_in(cw_over),
    .ccw_over_in(ccw_over), .speed_req_in(speed_req), .servo_enable_out(servo_enable_in),
    .cw_limit_out(cw_limit_in), .ccw_limit_out(ccw_limit_in), .motor_speed_out(motor_speed_in));

  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    ticks++;
    if (ticks == 60000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  // The request holds until pready is sampled high at a rising edge; read data is taken at that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    se = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  function automatic logic [31:0] pb();
    return {29'h0, ready_out, power_stage_on_out, brake_release_out};
  endfunction

  task automatic t_powerup();
    int n;
    n = 0;
    apb(1'b0, ADDR_CTRL, 32'h00000000);
    chk(rd, 32'h00000007);
    apb(1'b0, ADDR_RUN_WAIT, 32'h00000000);
    chk(rd, 32'h000001F4);
    apb(1'b0, 8'h3C, 32'h00000000);
    chk({rd[30:0], se}, 32'h00000001);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000001F);
    @(posedge clk_sys_in);
    son_req <= 1'b1;
    while (ready_out !== 1'b1 && n < 40000) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk({31'h0, n + 100 > READY_DELAY_MS * TICK && n <= READY_DELAY_MS * TICK}, 32'h00000001);
    chk(pb(), 32'h00000004);
    cyc(2);
    chk(pb(), 32'h00000007);
    chk({31'h0, irq_out}, 32'h00000001);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h00000000);
    chk(rd & 32'h00000003, 32'h00000003);
    cyc(1);
    chk({31'h0, irq_out}, 32'h00000000);
    $display("Test powerup done");
  endtask

  task automatic t_torque();
    @(posedge clk_sys_in);
    tq <= 16'h00C8;
    cyc(5);
    chk({16'h0, torque_out}, 32'h00000000);
    apb(1'b1, ADDR_CTRL, 32'h00000003);
    tq <= 16'h7FFF;
    cyc(3);
    chk({16'h0, torque_out}, 32'h0000012C);
    @(posedge clk_sys_in);
    tq <= 16'h8000;
    cyc(3);
    chk({16'h0, torque_out}, 32'h0000FED4);
    apb(1'b1, ADDR_INT_CCW, 32'h00000064);
    tq <= 16'h00C8;
    cyc(3);
    chk({16'h0, torque_out}, 32'h00000064);
    apb(1'b1, ADDR_TEST_LIM, 32'h00000050);
    apb(1'b1, ADDR_CTRL, 32'h00000013);
    tq <= 16'h8000;
    cyc(3);
    chk({16'h0, torque_out}, 32'h0000FFB0);
    $display("Test torque done");
  endtask

  task automatic t_overtravel();
    @(posedge clk_sys_in);
    cw_over <= 1'b1;
    ccw_over <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADDR_CTRL, 32'(s));
      tq <= 16'h0032;
      cyc(4);
      chk({16'h0, torque_out}, (s == 0 || s == 2) ? 32'h00000000 : 32'h00000032);
      @(posedge clk_sys_in);
      tq <= 16'hFFCE;
      cyc(4);
      chk({16'h0, torque_out}, (s < 2) ? 32'h00000000 : 32'h0000FFCE);
    end
    @(posedge clk_sys_in);
    cw_over <= 1'b0;
    ccw_over <= 1'b0;
    $display("Test overtravel done");
  endtask

  task automatic t_brake();
    apb(1'b1, ADDR_STILL_DELAY, 32'h00000002);
    son_req <= 1'b0;
    cyc(4);
    chk(pb(), 32'h00000006);
    cyc(30);
    chk(pb(), 32'h00000006);
    cyc(20);
    chk(pb(), 32'h00000004);
    @(posedge clk_sys_in);
    son_req <= 1'b1;
    speed_req <= 16'h03E8;
    cyc(4);
    chk(pb(), 32'h00000007);
    @(posedge clk_sys_in);
    son_req <= 1'b0;
    cyc(4);
    chk({31'h0, power_stage_on_out, brake_release_out}, 32'h00000001);
    @(posedge clk_sys_in);
    speed_req <= 16'h0191;
    cyc(4);
    chk({31'h0, brake_release_out}, 32'h00000001);
    @(posedge clk_sys_in);
    speed_req <= 16'h0190;
    cyc(4);
    chk({31'h0, power_stage_on_out, brake_release_out}, 32'h00000000);
    apb(1'b1, ADDR_RUN_WAIT, 32'h00000001);
    son_req <= 1'b1;
    speed_req <= 16'h03E8;
    cyc(4);
    @(posedge clk_sys_in);
    son_req <= 1'b0;
    cyc(TICK - 8);
    chk({31'h0, brake_release_out}, 32'h00000001);
    cyc(16);
    chk({31'h0, brake_release_out}, 32'h00000000);
    $display("Test brake done");
  endtask

  task automatic t_alarm();
    @(posedge clk_sys_in);
    son_req <= 1'b1;
    cyc(4);
    @(posedge clk_sys_in);
    alarm_in <= 1'b1;
    cyc(4);
    chk(pb(), 32'h00000000);
    chk({16'h0, torque_out}, 32'h00000000);
    chk({31'h0, irq_out}, 32'h00000001);
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000000);
    cyc(1);
    chk({31'h0, irq_out}, 32'h00000000);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h00000000);
    chk(rd & 32'h00000010, 32'h00000010);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000001F);
    cyc(1);
    chk({31'h0, irq_out}, 32'h00000000);
    @(posedge clk_sys_in);
    alarm_in <= 1'b0;
    cyc(4);
    chk({31'h0, ready_out}, 32'h00000001);
    $display("Test alarm done");
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_powerup();
    t_torque();
    t_overtravel();
    t_brake();
    t_alarm();
    results();
  end
endmodule
